// [serial_port_defs.vh]
/*
  Constants for the serial port control-word sequencer: I/O port decode,
  mode, command and status field positions, reset values and timing.
  Assumes it is included by bare name from the design files.
*/
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// I/O port decode, low eight address bits
`define SP_DATA_ADDR       8'hD8
`define SP_DATA_ALIAS      8'hDC
`define SP_CTRL_ADDR       8'hDA
`define SP_CTRL_ALIAS      8'hDE

// Mode word fields
`define MODE_FACTOR_LSB    0
`define MODE_LEN_LSB       2
`define MODE_PAR_EN        4
`define MODE_PAR_EVEN      5
`define MODE_STOP_LSB      6
`define MODE_SINGLE_SYNC   7
`define FACTOR_SYNC        2'h0
`define FACTOR_CODE_X1     2'h1
`define FACTOR_CODE_X16    2'h2
`define FACTOR_CODE_X64    2'h3
`define FACTOR_X16         16
`define FACTOR_X64         64
`define STOP_CODE_ONE      2'h1

// Command word fields
`define CMD_TX_EN          0
`define CMD_RX_EN          2
`define CMD_ERR_CLR        4
`define CMD_REINIT         6
`define CMD_HUNT           7

// Status word fields
`define ST_TX_READY        0
`define ST_RX_READY        1
`define ST_TX_EMPTY        2
`define ST_PAR_ERR         3
`define ST_OVERRUN         4
`define ST_FRAME_ERR       5
`define ST_SYNC_DET        6

// Reset values
`define MODE_RESET         8'h00
`define CMD_RESET          8'h00
`define SYNC_RESET         8'h00
`define RDATA_RESET        8'h00

// Timing
`define CLK_PERIOD_NS      25
`define INIT_GAP_NS        3200
`define INIT_GAP_CLKS      ((`INIT_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_DIV_DEF       4

`endif

// [two_entry_buffer.v]
/*
  Two-entry buffer with valid/ready on both sides, used in the
  transmit data path. Assumes a single clock and active-low async reset.
*/
`timescale 1ns/100ps
module two_entry_buffer #(
    parameter WIDTH = 8
) (
    input  wire             i_clk,
    input  wire             i_rst_b,
    input  wire             i_flush,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:1];   // Storage entries
    reg             wr_idx;      // Next entry to fill
    reg             rd_idx;      // Oldest entry
    reg [1:0]       fill;        // Number of entries held

    wire push = i_in_valid & o_in_ready;
    wire pop  = o_out_valid & i_out_ready;

    // Honest flags straight from the fill count
    assign o_in_ready  = (fill != 2'h2);
    assign o_out_valid = (fill != 2'h0);
    assign o_out_data  = mem[rd_idx];

    // Pointer and count update; flush drops whatever is held
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            fill   <= 2'h0;
        end else if (i_flush) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            fill   <= 2'h0;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            if (push & ~pop) begin
                fill <= fill + 2'h1;
            end else if (pop & ~push) begin
                fill <= fill - 2'h1;
            end
        end
    end

    // Data storage needs no reset
    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_idx] <= i_in_data;
        end
    end
endmodule

// [serial_port_control_word_sequencer.v]
/*
  Serial port with control-word sequencing: mode word, sync characters,
  then command words, plus transmit and receive engines and status.
  Assumes host I/O strobes are one-cycle pulses synchronous to I_CLOCK.
*/
`timescale 1ns/100ps
`include "serial_port_defs.vh"
module serial_port_control_word_sequencer #(
    parameter TICK_DIV = `TICK_DIV_DEF
) (
    input  wire       I_CLOCK,
    input  wire       I_RST_B,
    input  wire [7:0] I_ADDR,
    input  wire       I_IOW,
    input  wire       I_IOR,
    input  wire [7:0] I_WDATA,
    input  wire       I_RXD,
    output reg  [7:0] O_RDATA,
    output reg        O_TXD,
    output reg        O_TX_READY,
    output reg        O_RX_READY
);
    // Control sequencer states
    localparam SQ_MODE  = 2'h0;
    localparam SQ_SYNC1 = 2'h1;
    localparam SQ_SYNC2 = 2'h2;
    localparam SQ_CMD   = 2'h3;
    // Receiver states
    localparam RX_IDLE  = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_BITS  = 3'h2;
    localparam RX_HUNT  = 3'h3;
    localparam RX_HUNT2 = 3'h4;
    localparam RX_SYNC  = 3'h5;

    // Parity of the low n bits
    function par_of;
        input [7:0] d;
        input [3:0] n;
        integer i;
        begin
            par_of = 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                if (i < n) par_of = par_of ^ d[i];
            end
        end
    endfunction

    // Mask keeping the low n bits of a character
    function [7:0] len_mask;
        input [3:0] n;
        len_mask = 8'hFF >> (4'h8 - n);
    endfunction

    reg  [1:0]  seq;        // Which control word comes next
    reg  [7:0]  mode;       // Mode word
    reg  [7:0]  cmd;        // Latest command word
    reg  [7:0]  sync1;      // First sync pattern
    reg  [7:0]  sync2;      // Second sync pattern
    reg         active;     // A command has ended initialisation
    reg         tx_rdy;     // Transmitter ready flag
    reg         tx_busy;    // Character on the line
    reg  [11:0] tx_sh;      // Outgoing frame, LSB first
    reg  [3:0]  tx_left;    // Bits still to send
    reg  [15:0] tx_tim;     // Bit timer
    reg  [2:0]  rx_state;   // Receiver state
    reg  [15:0] rx_tim;     // Sample timer
    reg  [11:0] rx_sh;      // Incoming bits
    reg  [3:0]  rx_cnt;     // Bits taken so far
    reg  [7:0]  rx_win;     // Sliding window for sync hunt
    reg  [7:0]  rx_hold;    // Received character for the host
    reg         rx_rdy;     // Receiver ready flag
    reg         pe;         // Parity error
    reg         oe;         // Overrun error
    reg         fe;         // Framing error
    reg         syndet;     // Sync found

    // Port decode, either address of a pair works
    wire data_sel = (I_ADDR == `SP_DATA_ADDR) | (I_ADDR == `SP_DATA_ALIAS);
    wire ctrl_sel = (I_ADDR == `SP_CTRL_ADDR) | (I_ADDR == `SP_CTRL_ALIAS);
    wire ctrl_wr  = I_IOW & ctrl_sel;
    wire data_wr  = I_IOW & data_sel;
    wire data_rd  = I_IOR & data_sel;
    wire stat_rd  = I_IOR & ctrl_sel;
    wire cmd_wr   = ctrl_wr & (seq == SQ_CMD);
    wire reinit   = cmd_wr & I_WDATA[`CMD_REINIT];
    wire err_clr  = cmd_wr & ~I_WDATA[`CMD_REINIT] & I_WDATA[`CMD_ERR_CLR];
    wire hunt_cmd = cmd_wr & ~I_WDATA[`CMD_REINIT] & I_WDATA[`CMD_HUNT];

    // Mode word decode
    wire [1:0]  factor    = mode[`MODE_FACTOR_LSB+1:`MODE_FACTOR_LSB];
    wire        sync_mode = (factor == `FACTOR_SYNC);
    wire [3:0]  nd        = 4'h5 + {2'h0, mode[`MODE_LEN_LSB+1:`MODE_LEN_LSB]};
    wire        par_en    = mode[`MODE_PAR_EN];
    wire        par_even  = mode[`MODE_PAR_EVEN];
    // Half-stop code is stretched to two whole stop bits
    wire        stop2     = (mode[`MODE_STOP_LSB+1:`MODE_STOP_LSB] > `STOP_CODE_ONE);
    wire [31:0] per_full  = (factor == `FACTOR_CODE_X16) ? TICK_DIV * `FACTOR_X16 :
                            (factor == `FACTOR_CODE_X64) ? TICK_DIV * `FACTOR_X64 : TICK_DIV;
    wire [15:0] bit_per   = per_full[15:0];
    wire [7:0]  cmask     = len_mask(nd);
    wire        tx_en     = active & cmd[`CMD_TX_EN];
    wire        rx_en     = active & cmd[`CMD_RX_EN];

    // Control word sequencing
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            seq    <= SQ_MODE;
            mode   <= `MODE_RESET;
            cmd    <= `CMD_RESET;
            sync1  <= `SYNC_RESET;
            sync2  <= `SYNC_RESET;
            active <= 1'b0;
        end else if (ctrl_wr) begin
            case (seq)
                SQ_MODE: begin
                    mode   <= I_WDATA;
                    active <= 1'b0;
                    // Async skips both sync characters
                    if (I_WDATA[`MODE_FACTOR_LSB+1:`MODE_FACTOR_LSB] == `FACTOR_SYNC) begin
                        seq <= SQ_SYNC1;
                    end else begin
                        seq <= SQ_CMD;
                    end
                end
                SQ_SYNC1: begin
                    sync1 <= I_WDATA;
                    seq   <= mode[`MODE_SINGLE_SYNC] ? SQ_CMD : SQ_SYNC2;
                end
                SQ_SYNC2: begin
                    sync2 <= I_WDATA;
                    seq   <= SQ_CMD;
                end
                SQ_CMD: begin
                    if (I_WDATA[`CMD_REINIT]) begin
                        // Rest of the word is ignored
                        seq    <= SQ_MODE;
                        cmd    <= `CMD_RESET;
                        active <= 1'b0;
                    end else begin
                        cmd    <= I_WDATA;
                        active <= 1'b1;
                    end
                end
                default: seq <= SQ_MODE;
            endcase
        end
    end

    // Transmit buffer; data writes before initialisation are dropped
    wire       buf_in_ready;
    wire       buf_valid;
    wire [7:0] buf_data;
    wire       tx_take = ~tx_busy & tx_en;
    two_entry_buffer #(
        .WIDTH (8)
    ) u_tx_buffer (
        .i_clk       (I_CLOCK),
        .i_rst_b     (I_RST_B),
        .i_flush     (reinit),
        .i_in_valid  (data_wr & active),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (I_WDATA),
        .o_out_valid (buf_valid),
        .i_out_ready (tx_take),
        .o_out_data  (buf_data)
    );

    // Idle sync mode fills the line with the first sync pattern
    wire        tx_load = tx_take & (buf_valid | sync_mode);
    wire [7:0]  tx_char = (buf_valid ? buf_data : sync1) & cmask;
    wire        tx_par  = par_of(tx_char, nd) ^ ~par_even;
    reg  [11:0] tx_frame;   // Frame built for the next character
    reg  [3:0]  tx_len;     // Its length in bits
    integer     k;

    // Frame assembly: start, data, parity, stop for async
    always @* begin
        tx_frame = 12'hFFF;
        tx_len   = nd + {3'h0, par_en};
        if (sync_mode) begin
            for (k = 0; k < 8; k = k + 1) begin
                if (k < nd) tx_frame[k] = tx_char[k];
            end
            if (par_en) tx_frame[nd] = tx_par;
        end else begin
            tx_frame[0] = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (k < nd) tx_frame[k+1] = tx_char[k];
            end
            if (par_en) tx_frame[nd+4'h1] = tx_par;
            tx_len = nd + {3'h0, par_en} + (stop2 ? 4'h3 : 4'h2);
        end
    end

    // Transmit shifter
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tx_busy <= 1'b0;
            tx_sh   <= 12'hFFF;
            tx_left <= 4'h0;
            tx_tim  <= 16'h0000;
            O_TXD   <= 1'b1;
        end else if (reinit) begin
            tx_busy <= 1'b0;
            O_TXD   <= 1'b1;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_sh   <= tx_frame;
            tx_left <= tx_len;
            tx_tim  <= bit_per - 16'h0001;
            O_TXD   <= tx_frame[0];
        end else if (tx_busy) begin
            if (tx_tim != 16'h0000) begin
                tx_tim <= tx_tim - 16'h0001;
            end else if (tx_left == 4'h1) begin
                tx_busy <= 1'b0;
                O_TXD   <= sync_mode ? O_TXD : 1'b1;
            end else begin
                tx_sh   <= {1'b1, tx_sh[11:1]};
                O_TXD   <= tx_sh[1];
                tx_left <= tx_left - 4'h1;
                tx_tim  <= bit_per - 16'h0001;
            end
        end
    end

    // Receive word with the bit being sampled merged in
    reg [11:0] rx_word;
    always @* begin
        rx_word         = rx_sh;
        rx_word[rx_cnt] = I_RXD;
    end
    wire [7:0] rx_data  = rx_word[7:0] & cmask;
    wire [7:0] win_next = {I_RXD, rx_win[7:1]};
    wire [7:0] win_char = (win_next >> (4'h8 - nd)) & cmask;
    wire [3:0] rx_total = nd + {3'h0, par_en} + {3'h0, ~sync_mode};
    wire       rx_tick  = (rx_tim == 16'h0000);
    wire       rx_last  = rx_tick & (rx_cnt == rx_total - 4'h1);
    wire       deliver  = rx_last & ((rx_state == RX_BITS) | (rx_state == RX_SYNC));
    wire       bad_par  = par_en & (rx_word[nd] != (par_of(rx_data, nd) ^ ~par_even));
    wire       bad_stop = ~sync_mode & ~rx_word[nd+{3'h0, par_en}];

    // Receiver sequencing
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rx_state <= RX_IDLE;
            rx_tim   <= 16'h0000;
            rx_sh    <= 12'h000;
            rx_cnt   <= 4'h0;
            rx_win   <= 8'h00;
            syndet   <= 1'b0;
        end else if (!rx_en | reinit) begin
            rx_state <= RX_IDLE;
            syndet   <= 1'b0;
        end else if (hunt_cmd & sync_mode) begin
            rx_state <= RX_HUNT;
            rx_tim   <= bit_per - 16'h0001;
            syndet   <= 1'b0;
        end else begin
            rx_tim <= rx_tick ? bit_per - 16'h0001 : rx_tim - 16'h0001;
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= 4'h0;
                    if (sync_mode) begin
                        rx_state <= RX_HUNT;
                    end else if (!I_RXD) begin
                        // Start edge, check again at mid bit
                        // One cycle went into seeing the edge, so wait one less
                        rx_state <= RX_START;
                        rx_tim   <= (bit_per[15:1] == 15'h0000) ? 16'h0000 : {1'b0, bit_per[15:1]} - 16'h0001;
                    end
                end
                RX_START: begin
                    if (rx_tick) rx_state <= I_RXD ? RX_IDLE : RX_BITS;
                end
                RX_HUNT: begin
                    // Internal detection only: compare the window
                    if (rx_tick) begin
                        rx_win <= win_next;
                        rx_cnt <= 4'h0;
                        if (win_char == (sync1 & cmask)) begin
                            rx_state <= mode[`MODE_SINGLE_SYNC] ? RX_SYNC : RX_HUNT2;
                            syndet   <= mode[`MODE_SINGLE_SYNC];
                        end
                    end
                end
                RX_HUNT2: begin
                    if (rx_tick) begin
                        rx_sh  <= rx_word;
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt == nd - 4'h1) begin
                            rx_cnt   <= 4'h0;
                            syndet   <= (rx_data == (sync2 & cmask));
                            rx_state <= (rx_data == (sync2 & cmask)) ? RX_SYNC : RX_HUNT;
                        end
                    end
                end
                RX_BITS, RX_SYNC: begin
                    if (rx_tick) begin
                        rx_sh  <= rx_word;
                        rx_cnt <= rx_last ? 4'h0 : rx_cnt + 4'h1;
                        if (rx_last & ~sync_mode) rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Receive flags: a new character wins over a read or a clear
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rx_hold <= 8'h00;
            rx_rdy  <= 1'b0;
            pe      <= 1'b0;
            oe      <= 1'b0;
            fe      <= 1'b0;
        end else if (reinit) begin
            rx_rdy <= 1'b0;
            pe     <= 1'b0;
            oe     <= 1'b0;
            fe     <= 1'b0;
        end else begin
            if (deliver) begin
                rx_hold <= rx_data;
            end
            rx_rdy <= deliver | (rx_rdy & ~data_rd);
            oe     <= (deliver & rx_rdy & ~data_rd) | (oe & ~err_clr);
            pe     <= (deliver & bad_par) | (pe & ~err_clr);
            fe     <= (deliver & bad_stop) | (fe & ~err_clr);
        end
    end

    // Status word assembled from live flags
    wire [7:0] status = {1'b0, syndet, fe, oe, pe, ~tx_busy & ~buf_valid, rx_rdy, tx_rdy};

    // Ready flags, pins and host read data
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tx_rdy     <= 1'b0;
            O_TX_READY <= 1'b0;
            O_RX_READY <= 1'b0;
            O_RDATA    <= `RDATA_RESET;
        end else begin
            // Stays low until the command that ends initialisation
            tx_rdy     <= active & ~reinit & buf_in_ready;
            O_TX_READY <= active & ~reinit & buf_in_ready;
            O_RX_READY <= ~reinit & (deliver | (rx_rdy & ~data_rd));
            if (data_rd) begin
                O_RDATA <= rx_hold;
            end else if (stat_rd) begin
                O_RDATA <= status;
            end else begin
                O_RDATA <= `RDATA_RESET;
            end
        end
    end
endmodule

// [serial_port_checker_assertions.sv]
/*
  Assertion checker for the serial port sequencer, watching top-level ports only.
  Assumes the design header is on the include path; attached by the bind at the foot.
*/
`timescale 1ns/100ps
`include "serial_port_defs.vh"
module serial_port_checker #(
    parameter TICK_DIV = 4
) (
    input wire       I_CLOCK,
    input wire       I_RST_B,
    input wire [7:0] I_ADDR,
    input wire       I_IOW,
    input wire       I_IOR,
    input wire [7:0] I_WDATA,
    input wire       I_RXD,
    input wire [7:0] O_RDATA,
    input wire       O_TXD,
    input wire       O_TX_READY,
    input wire       O_RX_READY
);
    // Either address of each decoded port pair
    wire ctrl_sel = (I_ADDR == `SP_CTRL_ADDR) || (I_ADDR == `SP_CTRL_ALIAS);
    wire data_sel = (I_ADDR == `SP_DATA_ADDR) || (I_ADDR == `SP_DATA_ALIAS);

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);

    sequence status_read;
        I_IOR && ctrl_sel;
    endsequence
    sequence data_read;
        I_IOR && data_sel && O_RX_READY;
    endsequence
    sequence reinit_write;
        I_IOW && ctrl_sel && I_WDATA[`CMD_REINIT] && O_TX_READY;
    endsequence

    reset_idle_a: assert property ($rose(I_RST_B) |-> O_TXD && !O_TX_READY && !O_RX_READY)
        else $error("outputs not idle after reset");
    rdata_only_read_a: assert property (!$past(I_IOR) |-> O_RDATA == 8'h00)
        else $error("read data without a read");
    unmapped_zero_a: assert property (I_IOR && !ctrl_sel && !data_sel |=> O_RDATA == 8'h00)
        else $error("unmapped read returned data");
    status_flags_a: assert property (status_read |=> O_RDATA[`ST_TX_READY] == $past(O_TX_READY))
        else $error("status bit differs from ready pin");
    rx_clear_a: assert property (data_read |=> !O_RX_READY)
        else $error("receiver ready not cleared by read");
    reinit_drop_a: assert property (reinit_write |-> ##2 !O_TX_READY)
        else $error("reinit did not drop transmitter ready");
    tx_hold_a: assert property (O_TX_READY && !I_IOW && !$past(I_IOW) |=> O_TX_READY)
        else $error("transmitter ready fell without a write");
    rx_hold_a: assert property (O_RX_READY && !I_IOR && !I_IOW && !$past(I_IOW) |=> O_RX_READY)
        else $error("receiver ready fell without a read");
endmodule

bind serial_port_control_word_sequencer serial_port_checker #(.TICK_DIV(TICK_DIV)) checker_inst (
    .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_IOW(I_IOW), .I_IOR(I_IOR),
    .I_WDATA(I_WDATA), .I_RXD(I_RXD), .O_RDATA(O_RDATA), .O_TXD(O_TXD),
    .O_TX_READY(O_TX_READY), .O_RX_READY(O_RX_READY));

// [host_io_model.sv]
/*
  Host CPU model: one-cycle I/O write and read strobes toward the serial port.
  Assumes a free-running clock; requests start 2 ns after a rising edge.
*/
`timescale 1ns/100ps
module host_io_model (
    input  wire       i_clk,
    output reg  [7:0] o_addr,
    output reg        o_iow,
    output reg        o_ior,
    output reg  [7:0] o_wdata
);
    // Idle bus: no address, no strobes and zero write data
    initial begin
        o_addr = 8'h00;
        o_iow = 1'b0;
        o_ior = 1'b0;
        o_wdata = 8'h00;
    end

    // Write strobe, then scrambled lines so no stale value lingers, then a pause
    task wr(input [7:0] a, input [7:0] d, input integer gap);
        begin
            @(posedge i_clk);
            #2;
            o_addr = a;
            o_wdata = d;
            o_iow = 1'b1;
            @(posedge i_clk);
            #2;
            o_iow = 1'b0;
            o_addr = ~a;
            o_wdata = ~d;
            repeat (gap) @(posedge i_clk);
        end
    endtask

    // Read strobe; data is taken by the bench's monitor one cycle later
    task rd(input [7:0] a);
        begin
            @(posedge i_clk);
            #2;
            o_addr = a;
            o_ior = 1'b1;
            @(posedge i_clk);
            #2;
            o_ior = 1'b0;
            o_addr = ~a;
        end
    endtask
endmodule

// [serial_port_control_word_sequencer_bench.sv]
/*
  Self-checking bench for the serial port sequencer, with transmit looped to receive.
  Assumes the host model drives the I/O bus and the checker is bound in.
*/
`timescale 1ns/100ps
`include "serial_port_defs.vh"
module serial_port_control_word_sequencer_bench;
    reg         clock;
    reg         rst_b;
    wire [7:0]  addr, wdata, rdata;
    wire        iow, ior, txd, tx_ready, rx_ready;
    integer     mismatches, num_checks, seed, n, k;
    integer     cycles = 0;
    reg  [15:0] notes[$];   // Mask and expected value of each pending read
    reg  [7:0]  sent[$];    // Characters travelling on the loopback
    reg         rd_pend = 1'b0;
    reg  [15:0] note;
    reg  [7:0]  ch;

    // Small divider keeps frames short; the loopback feeds transmit into receive
    serial_port_control_word_sequencer #(.TICK_DIV(2)) serial_port_control_word_sequencer_inst (
        .I_CLOCK(clock), .I_RST_B(rst_b), .I_ADDR(addr), .I_IOW(iow), .I_IOR(ior),
        .I_WDATA(wdata), .I_RXD(txd), .O_RDATA(rdata), .O_TXD(txd),
        .O_TX_READY(tx_ready), .O_RX_READY(rx_ready));
    host_io_model host_io_model_inst (.i_clk(clock), .o_addr(addr), .o_iow(iow), .o_ior(ior), .o_wdata(wdata));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Note the expectation, then let the host read
    task expect_rd(input [7:0] a, input [7:0] mask, input [7:0] exp);
        begin
            notes.push_back({mask, exp});
            host_io_model_inst.rd(a);
        end
    endtask

    // Bounded wait for a received character
    task wait_rx;
        begin
            k = 0;
            while (rx_ready !== 1'b1 && k < 300) begin
                @(posedge clock);
                #2;
                k = k + 1;
            end
            chk({7'h00, rx_ready}, 8'h01);
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // Read data settles one cycle after the strobe; compare at the falling edge
    always @(posedge clock) begin
        rd_pend <= ior;
    end
    always @(negedge clock) begin
        if (rd_pend) begin
            note = notes.pop_front();
            chk(rdata & note[15:8], note[7:0]);
        end
    end

    // Hang guard
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_sim;
        end
    end

    initial begin
        seed = 32'h0000_0fea;
        mismatches = 0;
        num_checks = 0;
        rst_b = 1'b0;
        repeat (10) @(posedge clock);
        #2;
        rst_b = 1'b1;
        chk({7'h00, tx_ready}, 8'h00);
        expect_rd(`SP_CTRL_ADDR, 8'h01, 8'h00);
        host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h4D, `INIT_GAP_CLKS);
        host_io_model_inst.wr(`SP_DATA_ADDR, 8'h5A, `INIT_GAP_CLKS);
        chk({7'h00, tx_ready}, 8'h00);
        host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h05, 0);
        @(posedge clock);
        #2;
        chk({7'h00, tx_ready}, 8'h01);
        repeat (40) @(posedge clock);
        chk({7'h00, rx_ready}, 8'h00);
        // Fill the transmit path until refused, then one write that must be dropped
        n = 0;
        while (tx_ready === 1'b1 && n < 8) begin
            ch = $random(seed);
            sent.push_back(ch);
            host_io_model_inst.wr(n[0] ? `SP_DATA_ALIAS : `SP_DATA_ADDR, ch, 1);
            #2;
            n = n + 1;
        end
        host_io_model_inst.wr(`SP_DATA_ADDR, 8'hA5, 0);
        while (sent.size() > 0) begin
            wait_rx;
            expect_rd(`SP_DATA_ALIAS, 8'hFF, sent.pop_front());
        end
        repeat (60) @(posedge clock);
        expect_rd(`SP_CTRL_ALIAS, 8'h03, 8'h01);
        expect_rd(8'hD0, 8'hFF, 8'h00);
        host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h40, `INIT_GAP_CLKS);
        chk({7'h00, tx_ready}, 8'h00);
        // Single then double sync; a sync value with bit 6 set is not a reinit
        for (k = 0; k < 2; k = k + 1) begin
            host_io_model_inst.wr(`SP_CTRL_ADDR, k ? 8'h0C : 8'h8C, `INIT_GAP_CLKS);
            host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h40, `INIT_GAP_CLKS);
            if (k)
                host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h16, `INIT_GAP_CLKS);
            chk({7'h00, tx_ready}, 8'h00);
            host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h95, 0);
            @(posedge clock);
            #2;
            chk({7'h00, tx_ready}, 8'h01);
            ch = $random(seed);
            ch[6] = 1'b1;
            host_io_model_inst.wr(`SP_CTRL_ADDR, ch, `INIT_GAP_CLKS);
            chk({7'h00, tx_ready}, 8'h00);
        end
        // Async with even parity and two stop bits over the loopback
        host_io_model_inst.wr(`SP_CTRL_ALIAS, 8'hFD, `INIT_GAP_CLKS);
        host_io_model_inst.wr(`SP_CTRL_ADDR, 8'h15, 0);
        @(posedge clock);
        #2;
        expect_rd(`SP_CTRL_ADDR, 8'h01, 8'h01);
        ch = $random(seed);
        host_io_model_inst.wr(`SP_DATA_ALIAS, ch, 0);
        wait_rx;
        expect_rd(`SP_DATA_ADDR, 8'hFF, ch);
        expect_rd(`SP_CTRL_ADDR, 8'h3B, 8'h01);
        end_sim;
    end
endmodule
